/* core/pllc_pkg.sv */
// Package for the PLL lock and sleep clock controller.
// Assumes one 25 MHz system clock and a word-aligned 12-bit register offset.
package pllc_pkg;

    // Register byte offsets.
    localparam logic [11:0] RAW_IRQ_STATUS_OFF = 12'h050;
    localparam logic [11:0] IRQ_MASK_OFF = 12'h054;
    localparam logic [11:0] IRQ_MASKED_OFF = 12'h058;
    localparam logic [11:0] RESET_CAUSE_OFF = 12'h05C;
    localparam logic [11:0] RUN_CLOCK_CONFIG_OFF = 12'h060;
    localparam logic [11:0] RUN_CLOCK_CONFIG_EXT_OFF = 12'h070;
    localparam logic [11:0] MAIN_OSC_CONTROL_OFF = 12'h07C;
    localparam logic [11:0] RUN_GATE_OFF = 12'h100;
    localparam logic [11:0] SLEEP_GATE_OFF = 12'h110;
    localparam logic [11:0] DEEPSLEEP_GATE_OFF = 12'h120;
    localparam logic [11:0] DEEPSLEEP_CLOCK_CONFIG_OFF = 12'h144;
    localparam int GATE_WORDS = 3;

    // Reset values.
    localparam logic [31:0] RUN_CLOCK_CONFIG_RST = 32'h0780_3AD1;
    localparam logic [31:0] RUN_CLOCK_CONFIG_EXT_RST = 32'h0780_6810;
    localparam logic [31:0] GATE0_RST = 32'h0000_0040;
    localparam logic [31:0] GATE_RST = 32'h0000_0000;
    localparam logic [31:0] DEEPSLEEP_CLOCK_CONFIG_RST = 32'h0780_0000;

    // Run clock configuration fields.
    localparam int MAIN_OSC_DIS_BIT = 0;
    localparam int INT_OSC_DIS_BIT = 1;
    localparam int OSC_SRC_LSB = 4;
    localparam int CRYSTAL_SELECT_LSB = 6;
    localparam int BYPASS_BIT = 11;
    localparam int PLL_PLL_POWER_DOWN_BIT = 13;
    localparam int DIVIDER_USE_BIT = 22;
    localparam int SYS_DIV_LSB = 23;
    localparam int AUTO_GATE_BIT = 27;
    // Extended configuration fields.
    localparam int OSC_SRC_EXT_LSB = 4;
    localparam int SYS_DIV_EXT_LSB = 23;
    localparam int EXT_SELECT_BIT = 31;
    // Deep-sleep configuration fields.
    localparam int DS_OSC_LSB = 4;
    localparam int DS_DIV_LSB = 23;
    // Status and control bits.
    localparam int OSC_CHECK_EN_BIT = 0;
    localparam int OSC_FAIL_CAUSE_BIT = 16;
    localparam int PLL_LOCK_BIT = 6;

    // Oscillator source codes.
    localparam logic [2:0] OSC_MAIN = 3'h0;
    localparam logic [2:0] OSC_INTERNAL = 3'h1;

    // Relock timing in main oscillator periods; internal reset length in internal oscillator periods.
    localparam logic [15:0] RELOCK_SHORT = 16'h1200;
    localparam logic [15:0] RELOCK_LONG = 16'h2400;
    localparam logic [4:0] CRYSTAL_SELECT_LONG_LIMIT = 5'h0F;
    localparam logic [5:0] DIV_LIMIT_BASE = 6'h0F;
    localparam logic [5:0] INT_POR_PERIODS = 6'h20;

    typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_DEEP, PWR_WAKE} pllc_pwr_e;
    typedef enum logic [2:0] {
        FAIL_IDLE, FAIL_ENABLE_INTERNAL_OSC, FAIL_SWITCH, FAIL_RESET, FAIL_NMI
    } pllc_fail_e;

endpackage : pllc_pkg

/* core/pllc_relock.sv */
// Relock down counter for the PLL.
// Assumes tick_i is a one-cycle pulse per main oscillator period, already synchronised.
`timescale 1ns/1ps
`default_nettype none
module pllc_relock
    import pllc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic long_i,
    input wire logic tick_i,
    output logic done_o
);
    logic [15:0] count_q;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_q <= 16'h0000;
        end else if (start_i) begin
            count_q <= long_i ? RELOCK_LONG : RELOCK_SHORT;
        end else if (tick_i && count_q != 16'h0000) begin
            count_q <= count_q - 16'h0001;
        end
    end

    assign done_o = (count_q == 16'h0000) && !start_i;

endmodule : pllc_relock
`default_nettype wire

/* core/pllc_top.sv */
// Clock controller: PLL relock, oscillator check and sleep-mode clock gating.
// Assumes pins main_osc_tick_i, int_osc_tick_i and osc_freq_bad_i are asynchronous.
//
// Function
// - PLL output is not used as clock until the relock time has elapsed.
// - A write changing the crystal select starts relock; same value does not.
// - PLL leaving power-down starts a relock period.
// - Relock counts down on main oscillator periods from 0x1200 by default.
// - Crystal select above 0x0f loads 0x2400 instead.
// - Enabling and selecting PLL at once keeps the oscillator until relock ends.
// - Lock sets the raw PLL lock flag and a maskable interrupt.
// - Oscillator check works only while enabled and flags out-of-band frequency.
// - A detected oscillator failure first sets the failure reset cause bit.
// - Then internal oscillator is turned on and the system clock moves to it.
// - Then an internal reset lasts 32 internal periods and NMI is raised in the cycle of release.
// - Run mode clocks only peripherals enabled in the run gating set.
// - Sleep stops processor clock; peripherals use sleep set if auto-gating.
// - Deep-sleep stops processor clock; peripherals use deep set if auto-gating.
// - Deep-sleep source is main oscillator unless config picks internal one.
// - PLL running at deep-sleep entry is powered down; divider overridden, /16 or /64.
// - Deep-sleep exit restores source and divider first, then re-enables clocks.
// - Sleep only on processor request; an interrupt returns to run.
// - Extended-select bit makes the second configuration register take effect.
// - Crystal select picks PLL settings; clearing power-down powers the PLL.
// - Applied divisor is field plus one; PLL output is halved first.
`timescale 1ns/1ps
`default_nettype none
module pllc_top
    import pllc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [31:0] reg_rdata_o,
    input wire logic main_osc_tick_i,
    input wire logic int_osc_tick_i,
    input wire logic osc_freq_bad_i,
    input wire logic sleep_req_i,
    input wire logic deep_sleep_req_i,
    input wire logic wake_irq_i,
    output logic use_pll_o,
    output logic pll_prediv2_o,
    output logic [2:0] osc_source_o,
    output logic [6:0] sys_divisor_o,
    output logic pll_power_down_o,
    output logic main_osc_power_down_o,
    output logic int_osc_enable_o,
    output logic cpu_clk_enable_o,
    output logic [32*GATE_WORDS-1:0] periph_clk_enable_o,
    output logic internal_por_o,
    output logic nmi_request_o,
    output logic pll_lock_irq_o
);
    logic [31:0] run_clock_config_q;
    logic [31:0] run_clock_config_ext_q;
    logic [31:0] deepsleep_clock_config_q;
    logic osc_check_enable_q;
    logic osc_fail_cause_q;
    logic pll_lock_raw_flag_q;
    logic pll_lock_mask_q;
    logic [31:0] run_gate_regs_q [GATE_WORDS];
    logic [31:0] sleep_gate_regs_q [GATE_WORDS];
    logic [31:0] deepsleep_gate_regs_q [GATE_WORDS];
    logic [31:0] rdata_d;
    pllc_pwr_e pwr_q;
    pllc_fail_e fail_q;
    logic ds_pll_off_q;
    logic fail_internal_osc_on_q;
    logic fail_force_q;
    logic [5:0] por_count_q;
    logic pll_pd_prev_q;
    logic pll_ready_prev_q;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [2:0] sync3_q;
    logic [GATE_WORDS-1:0] hit_run;
    logic [GATE_WORDS-1:0] hit_sleep;
    logic [GATE_WORDS-1:0] hit_deep;

    // Three-stage synchronisers for the oscillator ticks and the frequency monitor.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            sync3_q <= 3'h0;
        end else begin
            sync1_q <= {osc_freq_bad_i, int_osc_tick_i, main_osc_tick_i};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    logic main_tick;
    logic int_tick;
    logic osc_bad;
    logic sync_main_prev_q;
    logic sync_int_prev_q;
    assign main_tick = sync2_q[0] && sync3_q[0] && !sync_main_prev_q;
    assign int_tick = sync2_q[1] && sync3_q[1] && !sync_int_prev_q;
    assign osc_bad = sync2_q[2] && sync3_q[2];

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_main_prev_q <= 1'b0;
            sync_int_prev_q <= 1'b0;
        end else begin
            if (sync2_q[0] == sync3_q[0]) begin
                sync_main_prev_q <= sync3_q[0];
            end
            if (sync2_q[1] == sync3_q[1]) begin
                sync_int_prev_q <= sync3_q[1];
            end
        end
    end

    // Active configuration, chosen by the extended-select bit.
    logic use_ext;
    logic eff_bypass;
    logic eff_pd;
    logic [2:0] eff_osc;
    logic [5:0] eff_div;
    logic [4:0] crystal_select;
    logic [2:0] ds_osc;
    logic [5:0] ds_div;
    logic deep_now;
    assign use_ext = run_clock_config_ext_q[EXT_SELECT_BIT];
    assign eff_bypass = use_ext ? run_clock_config_ext_q[BYPASS_BIT]
                                : run_clock_config_q[BYPASS_BIT];
    assign eff_pd = use_ext ? run_clock_config_ext_q[PLL_PLL_POWER_DOWN_BIT]
                            : run_clock_config_q[PLL_PLL_POWER_DOWN_BIT];
    assign eff_osc = use_ext ? run_clock_config_ext_q[OSC_SRC_EXT_LSB +: 3]
                             : {1'b0, run_clock_config_q[OSC_SRC_LSB +: 2]};
    assign eff_div = use_ext ? run_clock_config_ext_q[SYS_DIV_EXT_LSB +: 6]
                             : {2'b00, run_clock_config_q[SYS_DIV_LSB +: 4]};
    assign crystal_select = run_clock_config_q[CRYSTAL_SELECT_LSB +: 5];
    assign ds_osc = deepsleep_clock_config_q[DS_OSC_LSB +: 3];
    assign ds_div = deepsleep_clock_config_q[DS_DIV_LSB +: 6];
    assign deep_now = (pwr_q == PWR_DEEP);

    // PLL power and relock triggers.
    logic pll_pd_act;
    logic crystal_select_change;
    logic relock_start;
    logic relock_done;
    logic pll_ready;
    assign pll_pd_act = eff_pd || (deep_now && ds_pll_off_q);
    assign crystal_select_change = reg_we_i && reg_addr_i == RUN_CLOCK_CONFIG_OFF
                         && reg_wdata_i[CRYSTAL_SELECT_LSB +: 5] != crystal_select;
    assign relock_start = crystal_select_change || (pll_pd_prev_q && !pll_pd_act);

    pllc_relock u_relock (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .start_i(relock_start),
        .long_i(crystal_select_change ? reg_wdata_i[CRYSTAL_SELECT_LSB +: 5] > CRYSTAL_SELECT_LONG_LIMIT
                            : crystal_select > CRYSTAL_SELECT_LONG_LIMIT),
        .tick_i(main_tick),
        .done_o(relock_done)
    );

    assign pll_ready = relock_done && !pll_pd_act && !pll_pd_prev_q;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pll_pd_prev_q <= 1'b1;
            pll_ready_prev_q <= 1'b0;
        end else begin
            pll_pd_prev_q <= pll_pd_act;
            pll_ready_prev_q <= pll_ready;
        end
    end

    // Power mode sequencing.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pwr_q <= PWR_RUN;
            ds_pll_off_q <= 1'b0;
        end else begin
            case (pwr_q)
                PWR_RUN: begin
                    if (sleep_req_i) begin
                        pwr_q <= deep_sleep_req_i ? PWR_DEEP : PWR_SLEEP;
                        ds_pll_off_q <= deep_sleep_req_i && !eff_pd;
                    end
                end
                PWR_SLEEP: begin
                    if (wake_irq_i) begin
                        pwr_q <= PWR_RUN;
                    end
                end
                PWR_DEEP: begin
                    if (wake_irq_i) begin
                        pwr_q <= PWR_WAKE;
                    end
                end
                PWR_WAKE: begin
                    pwr_q <= PWR_RUN;
                    ds_pll_off_q <= 1'b0;
                end
                default: begin
                    pwr_q <= PWR_RUN;
                end
            endcase
        end
    end

    // Oscillator failure sequence.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fail_q <= FAIL_IDLE;
            fail_internal_osc_on_q <= 1'b0;
            fail_force_q <= 1'b0;
            por_count_q <= 6'h00;
        end else begin
            case (fail_q)
                FAIL_IDLE: begin
                    if (osc_check_enable_q && osc_bad && !fail_force_q) begin
                        fail_q <= FAIL_ENABLE_INTERNAL_OSC;
                    end else if (reg_we_i && reg_addr_i == RUN_CLOCK_CONFIG_OFF) begin
                        fail_force_q <= 1'b0;
                        fail_internal_osc_on_q <= 1'b0;
                    end
                end
                FAIL_ENABLE_INTERNAL_OSC: begin
                    fail_internal_osc_on_q <= 1'b1;
                    fail_q <= FAIL_SWITCH;
                end
                FAIL_SWITCH: begin
                    fail_force_q <= 1'b1;
                    por_count_q <= 6'h00;
                    fail_q <= FAIL_RESET;
                end
                FAIL_RESET: begin
                    if (int_tick) begin
                        por_count_q <= por_count_q + 6'h01;
                        if (por_count_q + 6'h01 == INT_POR_PERIODS) begin
                            fail_q <= FAIL_NMI;
                        end
                    end
                end
                FAIL_NMI: begin
                    fail_q <= FAIL_IDLE;
                end
                default: begin
                    fail_q <= FAIL_IDLE;
                end
            endcase
        end
    end

    // Register writes.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_clock_config_q <= RUN_CLOCK_CONFIG_RST;
            run_clock_config_ext_q <= RUN_CLOCK_CONFIG_EXT_RST;
            deepsleep_clock_config_q <= DEEPSLEEP_CLOCK_CONFIG_RST;
            osc_check_enable_q <= 1'b0;
            pll_lock_mask_q <= 1'b0;
        end else if (reg_we_i) begin
            case (reg_addr_i)
                RUN_CLOCK_CONFIG_OFF: run_clock_config_q <= reg_wdata_i;
                RUN_CLOCK_CONFIG_EXT_OFF: run_clock_config_ext_q <= reg_wdata_i;
                DEEPSLEEP_CLOCK_CONFIG_OFF: deepsleep_clock_config_q <= reg_wdata_i;
                MAIN_OSC_CONTROL_OFF: osc_check_enable_q <= reg_wdata_i[OSC_CHECK_EN_BIT];
                IRQ_MASK_OFF: pll_lock_mask_q <= reg_wdata_i[PLL_LOCK_BIT];
                default: begin
                end
            endcase
        end
    end

    // Lock flag and failure cause: a hardware set wins over a software clear.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pll_lock_raw_flag_q <= 1'b0;
            osc_fail_cause_q <= 1'b0;
        end else begin
            if (pll_ready && !pll_ready_prev_q) begin
                pll_lock_raw_flag_q <= 1'b1;
            end else if (reg_we_i && reg_addr_i == IRQ_MASKED_OFF
                         && reg_wdata_i[PLL_LOCK_BIT]) begin
                pll_lock_raw_flag_q <= 1'b0;
            end
            if (fail_q == FAIL_IDLE && osc_check_enable_q && osc_bad && !fail_force_q) begin
                osc_fail_cause_q <= 1'b1;
            end else if (reg_we_i && reg_addr_i == RESET_CAUSE_OFF) begin
                osc_fail_cause_q <= reg_wdata_i[OSC_FAIL_CAUSE_BIT];
            end
        end
    end

    // Gating words, one set per mode.
    genvar g;
    generate
        for (g = 0; g < GATE_WORDS; g++) begin : g_gate
            assign hit_run[g] = reg_addr_i == RUN_GATE_OFF + 12'(4 * g);
            assign hit_sleep[g] = reg_addr_i == SLEEP_GATE_OFF + 12'(4 * g);
            assign hit_deep[g] = reg_addr_i == DEEPSLEEP_GATE_OFF + 12'(4 * g);

            always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    run_gate_regs_q[g] <= (g == 0) ? GATE0_RST : GATE_RST;
                    sleep_gate_regs_q[g] <= (g == 0) ? GATE0_RST : GATE_RST;
                    deepsleep_gate_regs_q[g] <= (g == 0) ? GATE0_RST : GATE_RST;
                end else if (reg_we_i) begin
                    if (hit_run[g]) begin
                        run_gate_regs_q[g] <= reg_wdata_i;
                    end
                    if (hit_sleep[g]) begin
                        sleep_gate_regs_q[g] <= reg_wdata_i;
                    end
                    if (hit_deep[g]) begin
                        deepsleep_gate_regs_q[g] <= reg_wdata_i;
                    end
                end
            end

            always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    periph_clk_enable_o[32*g +: 32] <= GATE_RST;
                end else begin
                    case (pwr_q)
                        PWR_SLEEP: periph_clk_enable_o[32*g +: 32] <=
                            run_clock_config_q[AUTO_GATE_BIT] ? sleep_gate_regs_q[g]
                                                              : run_gate_regs_q[g];
                        PWR_DEEP, PWR_WAKE: periph_clk_enable_o[32*g +: 32] <=
                            run_clock_config_q[AUTO_GATE_BIT] ? deepsleep_gate_regs_q[g]
                                                              : run_gate_regs_q[g];
                        default: periph_clk_enable_o[32*g +: 32] <= run_gate_regs_q[g];
                    endcase
                end
            end
        end
    endgenerate

    // Read data, valid the cycle after the strobe.
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (reg_addr_i)
            RAW_IRQ_STATUS_OFF: rdata_d[PLL_LOCK_BIT] = pll_lock_raw_flag_q;
            IRQ_MASK_OFF: rdata_d[PLL_LOCK_BIT] = pll_lock_mask_q;
            IRQ_MASKED_OFF: rdata_d[PLL_LOCK_BIT] = pll_lock_raw_flag_q && pll_lock_mask_q;
            RESET_CAUSE_OFF: rdata_d[OSC_FAIL_CAUSE_BIT] = osc_fail_cause_q;
            RUN_CLOCK_CONFIG_OFF: rdata_d = run_clock_config_q;
            RUN_CLOCK_CONFIG_EXT_OFF: rdata_d = run_clock_config_ext_q;
            MAIN_OSC_CONTROL_OFF: rdata_d[OSC_CHECK_EN_BIT] = osc_check_enable_q;
            DEEPSLEEP_CLOCK_CONFIG_OFF: rdata_d = deepsleep_clock_config_q;
            default: begin
                for (int i = 0; i < GATE_WORDS; i++) begin
                    if (hit_run[i]) begin
                        rdata_d = run_gate_regs_q[i];
                    end
                    if (hit_sleep[i]) begin
                        rdata_d = sleep_gate_regs_q[i];
                    end
                    if (hit_deep[i]) begin
                        rdata_d = deepsleep_gate_regs_q[i];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            reg_rdata_o <= reg_re_i ? rdata_d : 32'h0000_0000;
        end
    end

    // Clock source, divider and oscillator controls.
    logic ds_internal;
    logic [5:0] div_field;
    assign ds_internal = deep_now && ds_osc != OSC_MAIN;

    always_comb begin
        if (deep_now && ds_pll_off_q) begin
            div_field = (!use_ext && ds_div > DIV_LIMIT_BASE) ? DIV_LIMIT_BASE : ds_div;
        end else if (run_clock_config_q[DIVIDER_USE_BIT]) begin
            div_field = eff_div;
        end else begin
            div_field = 6'h00;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            use_pll_o <= 1'b0;
            pll_prediv2_o <= 1'b0;
            osc_source_o <= OSC_MAIN;
            sys_divisor_o <= 7'h01;
            pll_power_down_o <= 1'b1;
            main_osc_power_down_o <= 1'b0;
            int_osc_enable_o <= 1'b0;
            pll_lock_irq_o <= 1'b0;
        end else begin
            use_pll_o <= !eff_bypass && pll_ready && !fail_force_q && !deep_now;
            pll_prediv2_o <= !eff_bypass && pll_ready && !fail_force_q && !deep_now;
            if (fail_force_q) begin
                osc_source_o <= OSC_INTERNAL;
            end else if (deep_now) begin
                osc_source_o <= ds_internal ? ds_osc : OSC_MAIN;
            end else begin
                osc_source_o <= eff_osc;
            end
            sys_divisor_o <= {1'b0, div_field} + 7'h01;
            pll_power_down_o <= pll_pd_act;
            main_osc_power_down_o <= ds_internal || run_clock_config_q[MAIN_OSC_DIS_BIT];
            int_osc_enable_o <= !run_clock_config_q[INT_OSC_DIS_BIT] || fail_internal_osc_on_q
                                || ds_internal;
            pll_lock_irq_o <= pll_lock_raw_flag_q && pll_lock_mask_q;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cpu_clk_enable_o <= 1'b1;
            internal_por_o <= 1'b0;
            nmi_request_o <= 1'b0;
        end else begin
            // The wake state keeps the processor off so the restored clock lands first.
            cpu_clk_enable_o <= pwr_q == PWR_RUN && !sleep_req_i;
            internal_por_o <= (fail_q == FAIL_SWITCH) || (fail_q == FAIL_RESET
                              && !(int_tick && por_count_q + 6'h01 == INT_POR_PERIODS));
            nmi_request_o <= (fail_q == FAIL_RESET && int_tick
                              && por_count_q + 6'h01 == INT_POR_PERIODS);
        end
    end

endmodule : pllc_top
`default_nettype wire

/* test/pllc_monitor.sv */
// Port-level assertions for pllc_top.
// Assumes binding to pllc_top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module pllc_monitor (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic reg_re_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic sleep_req_i,
    input wire logic deep_sleep_req_i,
    input wire logic use_pll_o,
    input wire logic pll_prediv2_o,
    input wire logic pll_power_down_o,
    input wire logic [2:0] osc_source_o,
    input wire logic [6:0] sys_divisor_o,
    input wire logic cpu_clk_enable_o,
    input wire logic internal_por_o,
    input wire logic nmi_request_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    rdata_idle_a: assert property (!$past(reg_re_i) |-> reg_rdata_o == 32'h0000_0000)
        else $error("read data outside its slot");
    relock_hold_a: assert property ($fell(pll_power_down_o) |=> !use_pll_o [*8])
        else $error("PLL used before relock");
    prediv_a: assert property (use_pll_o == pll_prediv2_o)
        else $error("PLL halving out of step");
    sleep_stop_a: assert property (sleep_req_i && cpu_clk_enable_o |=> !cpu_clk_enable_o)
        else $error("processor clock kept in sleep");
    deep_pll_off_a: assert property
        (sleep_req_i && deep_sleep_req_i && cpu_clk_enable_o && use_pll_o |-> ##2 pll_power_down_o)
        else $error("PLL left running in deep sleep");
    restore_first_a: assert property
        ($rose(cpu_clk_enable_o) |-> $stable(osc_source_o) && $stable(sys_divisor_o))
        else $error("clocks enabled before restore");
    por_length_a: assert property ($rose(internal_por_o) |=> internal_por_o [*8])
        else $error("internal reset too short");
    nmi_pulse_a: assert property (nmi_request_o |=> !nmi_request_o)
        else $error("NMI request longer than one cycle");
endmodule : pllc_monitor
bind pllc_top pllc_monitor pllc_monitor_i (.sys_clk_i, .rstn_i, .reg_re_i, .reg_rdata_o,
    .sleep_req_i, .deep_sleep_req_i, .use_pll_o, .pll_prediv2_o, .pll_power_down_o,
    .osc_source_o, .sys_divisor_o, .cpu_clk_enable_o, .internal_por_o, .nmi_request_o);
`default_nettype wire

/* test/test_pllc_top.sv */
// Self-checking bench for pllc_top.
// Assumes pllc_pkg and the design are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_pllc_top;
    import pllc_pkg::*;
    logic sys_clk_i = 0, rstn_i = 0, reg_we_i = 0, reg_re_i = 0, main_osc_tick_i = 0;
    logic int_osc_tick_i = 0, osc_freq_bad_i = 0, sleep_req_i = 0, deep_sleep_req_i = 0;
    logic wake_irq_i = 0, use_pll_o, internal_por_o, pll_power_down_o, cpu_clk_enable_o;
    logic [11:0] reg_addr_i = 12'h000;
    logic [31:0] reg_wdata_i = 32'h0000_0000, reg_rdata_o, v;
    logic [2:0] osc_source_o;
    int num_errors = 0, n_tests = 0, cyc = 0, n;
    logic [43:0] rows [6] = '{{RUN_CLOCK_CONFIG_OFF, RUN_CLOCK_CONFIG_RST},
        {RUN_CLOCK_CONFIG_EXT_OFF, RUN_CLOCK_CONFIG_EXT_RST}, {RUN_GATE_OFF, GATE0_RST},
        {DEEPSLEEP_CLOCK_CONFIG_OFF, DEEPSLEEP_CLOCK_CONFIG_RST},
        {RAW_IRQ_STATUS_OFF, GATE_RST}, {12'h200, GATE_RST}};
    pllc_top pllc_top_i (.sys_clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
        .reg_re_i, .reg_rdata_o, .main_osc_tick_i, .int_osc_tick_i, .osc_freq_bad_i,
        .sleep_req_i, .deep_sleep_req_i, .wake_irq_i, .use_pll_o, .pll_prediv2_o(),
        .osc_source_o, .sys_divisor_o(), .pll_power_down_o, .main_osc_power_down_o(),
        .int_osc_enable_o(), .cpu_clk_enable_o, .periph_clk_enable_o(), .internal_por_o,
        .nmi_request_o(), .pll_lock_irq_o());
    always #20 sys_clk_i = ~sys_clk_i;
    // Both oscillators run at a quarter of the system rate so every tick passes the filter.
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc % 2 == 1) begin
            main_osc_tick_i <= ~main_osc_tick_i;
            int_osc_tick_i <= ~int_osc_tick_i;
        end
        if (cyc == 60000) begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(logic [11:0] a, logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= 1;
        @(posedge sys_clk_i);
        reg_we_i <= 0;
        @(posedge sys_clk_i);
    endtask : wr
    task automatic rd(logic [11:0] a);
        reg_addr_i <= a;
        reg_re_i <= 1;
        @(posedge sys_clk_i);
        reg_re_i <= 0;
        #1 v = reg_rdata_o;
        @(posedge sys_clk_i);
    endtask : rd
    task automatic wait_for(ref logic s, input logic lv);
        n = 0;
        while (s !== lv && n < 40000) begin
            @(negedge sys_clk_i);
            n++;
        end
        @(posedge sys_clk_i);
    endtask : wait_for
    task automatic report_and_stop();
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (5) @(posedge sys_clk_i);
        rstn_i <= 1;
        @(posedge sys_clk_i);
        foreach (rows[i]) begin
            rd(rows[i][43:32]);
            chk("reset value", rows[i][31:0], v);
        end
        wr(RUN_CLOCK_CONFIG_OFF, 32'h0780_12D1);
        wait_for(use_pll_o, 1'b1);
        chk("short relock", 1, n >= 4 * RELOCK_SHORT - 8 && n <= 4 * RELOCK_SHORT + 8);
        rd(RAW_IRQ_STATUS_OFF);
        chk("lock flag", 1, v[PLL_LOCK_BIT]);
        wr(RUN_CLOCK_CONFIG_OFF, 32'h0780_1C01);
        wr(RUN_CLOCK_CONFIG_OFF, 32'h0780_1401);
        wait_for(use_pll_o, 1'b1);
        chk("long relock", 1, n >= 4 * RELOCK_LONG - 8 && n <= 4 * RELOCK_LONG + 8);
        wr(RUN_CLOCK_CONFIG_OFF, 32'h0780_1401);
        repeat (20) @(posedge sys_clk_i);
        chk("same crystal", 1, use_pll_o);
        sleep_req_i <= 1;
        deep_sleep_req_i <= 1;
        @(posedge sys_clk_i);
        sleep_req_i <= 0;
        deep_sleep_req_i <= 0;
        #1 chk("deep cpu off", 0, cpu_clk_enable_o);
        @(posedge sys_clk_i);
        wake_irq_i <= 1;
        #1 chk("deep pll off", 1, pll_power_down_o);
        @(posedge sys_clk_i);
        wake_irq_i <= 0;
        wait_for(cpu_clk_enable_o, 1'b1);
        chk("wake", 1, n < 8);
        wr(MAIN_OSC_CONTROL_OFF, 32'h0000_0001);
        osc_freq_bad_i <= 1;
        wait_for(internal_por_o, 1'b1);
        #1 chk("fail source", OSC_INTERNAL, osc_source_o);
        wait_for(internal_por_o, 1'b0);
        chk("por length", 1, n >= 4 * INT_POR_PERIODS - 8 && n <= 4 * INT_POR_PERIODS + 8);
        osc_freq_bad_i <= 0;
        rd(RESET_CAUSE_OFF);
        chk("fail cause", 1, v[OSC_FAIL_CAUSE_BIT]);
        report_and_stop();
    end
endmodule : test_pllc_top
`default_nettype wire
